/* rtl/clock_control_pkg.sv */
// shared constants, field layouts and types of the clock control block
package clock_control_pkg;

   // register byte offsets on the APB
   localparam logic [11:0] OSC_CTRL_ADDR = 12'h000;
   localparam logic [11:0] CLK_DIV_ADDR = 12'h004;
   localparam logic [11:0] PLL_FB_ADDR = 12'h008;
   localparam logic [11:0] RC_TRIM_ADDR = 12'h00C;
   localparam logic [11:0] UNLOCK_ADDR = 12'h010;

   // oscillator_control field positions
   localparam int CUR_SRC_LSB = 12;
   localparam int NEW_SRC_LSB = 8;
   localparam int LOCK_BIT = 5;
   localparam int FAIL_BIT = 3;
   localparam int SEC_OSC_BIT = 1;
   localparam int SWITCH_BIT = 0;

   // clock_divisor_control field positions
   localparam int RECOVER_BIT = 15;
   localparam int REDUCTION_LSB = 12;
   localparam int REDUCTION_EN_BIT = 11;
   localparam int RC_POST_LSB = 8;
   localparam int PLL_POST_LSB = 6;
   localparam int PLL_PRE_LSB = 0;

   // reset values, and the reserved PLL postscaler code
   localparam logic [2:0] REDUCTION_RESET = 3'h3;
   localparam logic [2:0] RC_POST_RESET = 3'h0;
   localparam logic [1:0] PLL_POST_RESET = 2'h1;
   localparam logic [4:0] PLL_PRE_RESET = 5'h00;
   localparam logic [8:0] PLL_MULT_RESET = 9'h030;
   localparam logic [5:0] RC_TRIM_RESET = 6'h00;
   localparam logic [1:0] PLL_POST_RESERVED = 2'h2;

   // source codes
   localparam logic [2:0] SRC_FAST_RC = 3'h0;
   localparam logic [2:0] SRC_RC_MULT = 3'h1;
   localparam logic [2:0] SRC_PRIMARY = 3'h2;
   localparam logic [2:0] SRC_PRIMARY_MULT = 3'h3;

   // unlock keys, written in this order to UNLOCK_ADDR
   localparam logic [7:0] UNLOCK_KEY_FIRST = 8'hA5;
   localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h3C;

   // cycles of the new clock to wait before the switch-over
   localparam logic [3:0] SETTLE_CYCLES = 4'hA;
   // edges after reset before fuses are trusted
   localparam logic [1:0] FUSE_SETTLE = 2'h3;

   typedef struct packed {
      logic recover_on_interrupt;
      logic [2:0] reduction_ratio;
      logic reduction_enable;
      logic [2:0] rc_postscaler;
      logic [1:0] pll_postscaler;
      logic [4:0] pll_prescaler;
   } clk_div_s;

   typedef struct packed {
      logic [3:0] pll_postscale;
      logic [5:0] pll_prescale;
      logic [9:0] pll_multiply;
      logic [8:0] rc_divide;
      logic signed [5:0] rc_trim;
   } clock_setting_s;

   typedef enum logic [1:0] {
      SW_IDLE,
      SW_START,
      SW_WAIT_SOURCE,
      SW_SETTLE
   } switch_state_e;

   typedef enum logic [1:0] {
      UL_LOCKED,
      UL_FIRST_KEY,
      UL_OPEN
   } unlock_state_e;

endpackage

/* rtl/unlock_guard.sv */
// two-key unlock sequence guarding writes to oscillator_control
module unlock_guard
   import clock_control_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // register write strobes
   input wire logic wr_stb,
   input wire logic wr_unlock,
   input wire logic wr_osc,
   input wire logic [7:0] wr_data,
   // unlock state
   output logic unlocked
);

   unlock_state_e state_q, state_d;

   always_comb begin
      state_d = state_q;
      if (wr_stb) begin
         // any other write closes the sequence
         if (wr_unlock && wr_data == UNLOCK_KEY_FIRST) begin
            state_d = UL_FIRST_KEY;
         end else if (wr_unlock && wr_data == UNLOCK_KEY_SECOND &&
                      state_q == UL_FIRST_KEY) begin
            state_d = UL_OPEN;
         end else begin
            state_d = UL_LOCKED;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= UL_LOCKED;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // open only for the oscillator write itself
   assign unlocked = (state_q == UL_OPEN) && wr_osc;

endmodule

/* rtl/doze_divider.sv */
// processor clock reduction: one cpu tick every 2^code peripheral cycles
module doze_divider
   import clock_control_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // ratio control
   input wire logic reduction_enable,
   input wire logic [2:0] reduction_ratio,
   // cpu clock enable
   output logic cpu_tick
);

   logic [6:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   logic [6:0] last;

   always_comb begin
      // ratio forced to 1:1 while reduction is off
      last = reduction_enable ? 7'((8'h01 << reduction_ratio) - 8'h01)
                              : 7'h00;
      tick_d = (cnt_q >= last);
      cnt_d = tick_d ? 7'h00 : 7'(cnt_q + 7'h01);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 7'h00;
         tick_q <= 1'b0;
      end else if (clk_en) begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign cpu_tick = tick_q;

endmodule

/* rtl/clock_control.sv */
// oscillator switch and divider control with APB register access
// Operation
// - monitor failure sets clock-fail flag, software clears
// - enable bit turns secondary oscillator on
// - switch request set by software, cleared when done
// - recover-on-interrupt clears reduction enable
// - reduction code divides by 1 to 128
// - reduction applies only while enabled
// - RC postscaler divides 1..64, code 7 256
// - PLL postscaler 2, 4, 8; code 10 reserved
// - PLL prescaler is field plus two
// - PLL multiplier is field plus two
// - RC trim is signed two's-complement step
// - unimplemented bits read zero, ignore writes
// - oscillator control writes need unlock sequence
// - primary submode fixed by fuses only
// - switching and monitor need fuse programmed 0
// - disabled: current source follows initial fuse
// - disabled: switch request held at zero
// - equal sources abort the switch request
// - valid switch start clears lock and fail
// - wait ten new-clock cycles after start-up
// - completion clears request, copies new to current
module clock_control
   import clock_control_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // configuration fuses
   input wire logic switch_enable_fuse,
   input wire logic [2:0] initial_source_fuse,
   input wire logic [1:0] primary_submode_fuse,
   // oscillator status pins
   input wire logic clock_fail_detect,
   input wire logic pll_locked,
   input wire logic new_source_ready,
   input wire logic new_clock,
   // interrupt activity from the same clock domain
   input wire logic interrupt_event,
   // clock selection outputs
   output logic [2:0] active_source,
   output logic [2:0] target_source,
   output logic [1:0] primary_submode,
   output logic secondary_osc_on,
   output logic switch_busy,
   output logic fail_safe_monitor_on,
   // divider settings
   output logic [8:0] rc_divide,
   output logic [5:0] pll_prescale,
   output logic [9:0] pll_multiply,
   output logic [3:0] pll_postscale,
   output logic signed [5:0] rc_trim,
   // cpu clock reduction
   output logic reduction_active,
   output logic cpu_tick
);

   localparam int SYNC_W = 10;

   // register index of a byte address, zero when unmapped
   function automatic logic [2:0] reg_index(input logic [11:0] addr);
      logic [2:0] idx;
      idx = 3'h0;
      if (addr == OSC_CTRL_ADDR) begin
         idx = 3'h1;
      end else if (addr == CLK_DIV_ADDR) begin
         idx = 3'h2;
      end else if (addr == PLL_FB_ADDR) begin
         idx = 3'h3;
      end else if (addr == RC_TRIM_ADDR) begin
         idx = 3'h4;
      end else if (addr == UNLOCK_ADDR) begin
         idx = 3'h5;
      end
      return idx;
   endfunction

   function automatic logic uses_multiplier(input logic [2:0] src);
      return (src == SRC_RC_MULT) || (src == SRC_PRIMARY_MULT);
   endfunction

   // pin synchronisers
   logic [SYNC_W-1:0] pins;
   logic [SYNC_W-1:0] meta_q, sync_q;
   logic clock_prev_q;

   assign pins = {new_clock, new_source_ready, pll_locked, clock_fail_detect,
                  primary_submode_fuse, initial_source_fuse,
                  switch_enable_fuse};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
         clock_prev_q <= 1'b0;
      end else if (clk_en) begin
         meta_q <= pins;
         sync_q <= meta_q;
         clock_prev_q <= sync_q[9];
      end
   end

   logic fuse_switch_off;
   logic [2:0] fuse_source;
   logic [1:0] fuse_submode;
   logic fail_s, lock_s, ready_s, clock_rise;
   logic switching_on;

   assign fuse_switch_off = sync_q[0];
   assign fuse_source = sync_q[3:1];
   assign fuse_submode = sync_q[5:4];
   assign fail_s = sync_q[6];
   assign lock_s = sync_q[7];
   assign ready_s = sync_q[8];
   assign clock_rise = sync_q[9] && !clock_prev_q;
   assign switching_on = !fuse_switch_off;

   // apb decode
   logic setup_phase, wr_stb;
   logic [2:0] wr_idx;
   logic wr_osc, unlocked;

   assign setup_phase = psel && !penable;
   assign wr_stb = psel && penable && pready && pwrite;
   assign wr_idx = reg_index(paddr);

   unlock_guard u_unlock (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .wr_stb(wr_stb),
      .wr_unlock(wr_idx == 3'h5),
      .wr_osc(wr_idx == 3'h1),
      .wr_data(pwdata[7:0]),
      .unlocked(unlocked)
   );

   assign wr_osc = wr_stb && (wr_idx == 3'h1) && unlocked;

   // oscillator control and switch sequencer
   switch_state_e state_q, state_d;
   logic [2:0] cur_q, cur_d, new_q, new_d;
   logic lock_q, lock_d, fail_q, fail_d, sec_q, sec_d, req_q, req_d;
   logic [3:0] settle_q, settle_d;
   logic [1:0] init_q, init_d;

   always_comb begin
      state_d = state_q;
      cur_d = cur_q;
      new_d = new_q;
      lock_d = lock_s;
      fail_d = fail_q;
      sec_d = sec_q;
      req_d = req_q;
      settle_d = settle_q;
      init_d = init_q;
      // fuses reloaded on every edge until the synchronisers have filled
      if (init_q != FUSE_SETTLE) begin
         init_d = 2'(init_q + 2'h1);
         cur_d = fuse_source;
         new_d = fuse_source;
      end
      if (wr_osc) begin
         new_d = pwdata[NEW_SRC_LSB +: 3];
         sec_d = pwdata[SEC_OSC_BIT];
         if (!pwdata[FAIL_BIT]) begin
            fail_d = 1'b0;
         end
         if (pwdata[SWITCH_BIT]) begin
            req_d = 1'b1;
         end
      end
      case (state_q)
         SW_IDLE: begin
            if (req_q && init_q == FUSE_SETTLE) begin
               if (new_q == cur_q) begin
                  req_d = 1'b0;
               end else begin
                  state_d = SW_START;
               end
            end
         end
         SW_START: begin
            lock_d = 1'b0;
            fail_d = 1'b0;
            state_d = SW_WAIT_SOURCE;
         end
         SW_WAIT_SOURCE: begin
            // start-up timer and, for multiplied sources, lock first
            if (ready_s && (!uses_multiplier(new_q) || lock_q)) begin
               settle_d = 4'h0;
               state_d = SW_SETTLE;
            end
         end
         SW_SETTLE: begin
            if (clock_rise) begin
               settle_d = 4'(settle_q + 4'h1);
               if (settle_q == 4'(SETTLE_CYCLES - 4'h1)) begin
                  cur_d = new_q;
                  req_d = 1'b0;
                  state_d = SW_IDLE;
               end
            end
         end
         default: state_d = SW_IDLE;
      endcase
      if (!switching_on) begin
         req_d = 1'b0;
         cur_d = fuse_source;
         state_d = SW_IDLE;
      end
      // a failure in the clearing cycle is kept: set wins
      if (switching_on && fail_s) begin
         fail_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SW_IDLE;
         cur_q <= SRC_FAST_RC;
         new_q <= SRC_FAST_RC;
         lock_q <= 1'b0;
         fail_q <= 1'b0;
         sec_q <= 1'b0;
         req_q <= 1'b0;
         settle_q <= 4'h0;
         init_q <= 2'h0;
      end else if (clk_en) begin
         state_q <= state_d;
         cur_q <= cur_d;
         new_q <= new_d;
         lock_q <= lock_d;
         fail_q <= fail_d;
         sec_q <= sec_d;
         req_q <= req_d;
         settle_q <= settle_d;
         init_q <= init_d;
      end
   end

   // divider, multiplier and trim registers
   clk_div_s div_q, div_d;
   logic [8:0] mult_q, mult_d;
   logic [5:0] trim_q, trim_d;

   always_comb begin
      div_d = div_q;
      mult_d = mult_q;
      trim_d = trim_q;
      if (wr_stb && wr_idx == 3'h2) begin
         div_d.recover_on_interrupt = pwdata[RECOVER_BIT];
         div_d.reduction_ratio = pwdata[REDUCTION_LSB +: 3];
         div_d.reduction_enable = pwdata[REDUCTION_EN_BIT];
         div_d.rc_postscaler = pwdata[RC_POST_LSB +: 3];
         // the reserved postscaler code is never stored
         if (pwdata[PLL_POST_LSB +: 2] != PLL_POST_RESERVED) begin
            div_d.pll_postscaler = pwdata[PLL_POST_LSB +: 2];
         end
         div_d.pll_prescaler = pwdata[PLL_PRE_LSB +: 5];
      end
      if (wr_stb && wr_idx == 3'h3) begin
         mult_d = pwdata[8:0];
      end
      if (wr_stb && wr_idx == 3'h4) begin
         trim_d = pwdata[5:0];
      end
      // interrupt wins over a software write in the same cycle
      if (div_q.recover_on_interrupt && interrupt_event) begin
         div_d.reduction_enable = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '{recover_on_interrupt: 1'b0,
                    reduction_ratio: REDUCTION_RESET,
                    reduction_enable: 1'b0,
                    rc_postscaler: RC_POST_RESET,
                    pll_postscaler: PLL_POST_RESET,
                    pll_prescaler: PLL_PRE_RESET};
         mult_q <= PLL_MULT_RESET;
         trim_q <= RC_TRIM_RESET;
      end else if (clk_en) begin
         div_q <= div_d;
         mult_q <= mult_d;
         trim_q <= trim_d;
      end
   end

   // apb answer registered in the setup cycle
   logic [31:0] rd_word, prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;

   always_comb begin
      rd_word = 32'h0000_0000;
      if (wr_idx == 3'h1) begin
         rd_word[CUR_SRC_LSB +: 3] = cur_q;
         rd_word[NEW_SRC_LSB +: 3] = new_q;
         rd_word[LOCK_BIT] = lock_q;
         rd_word[FAIL_BIT] = fail_q;
         rd_word[SEC_OSC_BIT] = sec_q;
         rd_word[SWITCH_BIT] = req_q;
      end else if (wr_idx == 3'h2) begin
         rd_word[RECOVER_BIT] = div_q.recover_on_interrupt;
         rd_word[REDUCTION_LSB +: 3] = div_q.reduction_ratio;
         rd_word[REDUCTION_EN_BIT] = div_q.reduction_enable;
         rd_word[RC_POST_LSB +: 3] = div_q.rc_postscaler;
         rd_word[PLL_POST_LSB +: 2] = div_q.pll_postscaler;
         rd_word[PLL_PRE_LSB +: 5] = div_q.pll_prescaler;
      end else if (wr_idx == 3'h3) begin
         rd_word[8:0] = mult_q;
      end else if (wr_idx == 3'h4) begin
         rd_word[5:0] = trim_q;
      end
      pready_d = setup_phase;
      pslverr_d = setup_phase && (wr_idx == 3'h0);
      prdata_d = setup_phase ? rd_word : prdata_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // registered clock settings for the analog side
   clock_setting_s set_q, set_d;
   logic [2:0] act_q, tgt_q;
   logic [1:0] sub_q;
   logic sec_on_q, busy_q, monitor_q, red_q;

   always_comb begin
      // code 7 jumps to 256 rather than continuing the doubling
      set_d.rc_divide = (div_q.rc_postscaler == 3'h7) ? 9'h100
                        : 9'(9'h001 << div_q.rc_postscaler);
      set_d.pll_prescale = 6'({1'b0, div_q.pll_prescaler} + 6'h02);
      set_d.pll_multiply = 10'({1'b0, mult_q} + 10'h002);
      case (div_q.pll_postscaler)
         2'h0: set_d.pll_postscale = 4'h2;
         2'h3: set_d.pll_postscale = 4'h8;
         default: set_d.pll_postscale = 4'h4;
      endcase
      set_d.rc_trim = $signed(trim_q);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         set_q <= '0;
         act_q <= SRC_FAST_RC;
         tgt_q <= SRC_FAST_RC;
         sub_q <= 2'h0;
         sec_on_q <= 1'b0;
         busy_q <= 1'b0;
         monitor_q <= 1'b0;
         red_q <= 1'b0;
      end else if (clk_en) begin
         set_q <= set_d;
         act_q <= cur_q;
         // target follows request only while switching
         tgt_q <= (switching_on && state_q != SW_IDLE) ? new_q : cur_q;
         sub_q <= fuse_submode;
         sec_on_q <= sec_q;
         busy_q <= (state_q != SW_IDLE);
         monitor_q <= switching_on;
         red_q <= div_q.reduction_enable;
      end
   end

   assign active_source = act_q;
   assign target_source = tgt_q;
   assign primary_submode = sub_q;
   assign secondary_osc_on = sec_on_q;
   assign switch_busy = busy_q;
   assign fail_safe_monitor_on = monitor_q;
   assign rc_divide = set_q.rc_divide;
   assign pll_prescale = set_q.pll_prescale;
   assign pll_multiply = set_q.pll_multiply;
   assign pll_postscale = set_q.pll_postscale;
   assign rc_trim = set_q.rc_trim;
   assign reduction_active = red_q;

   doze_divider u_doze (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .reduction_enable(div_q.reduction_enable),
      .reduction_ratio(div_q.reduction_ratio),
      .cpu_tick(cpu_tick)
   );

endmodule

/* testbench/clock_control_assertions.sv */
// concurrent checks on clock_control's ports
module clock_control_assertions
   import clock_control_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // fuses
   input wire logic switch_enable_fuse,
   input wire logic [2:0] initial_source_fuse,
   // status and settings
   input wire logic [2:0] active_source,
   input wire logic [2:0] target_source,
   input wire logic switch_busy,
   input wire logic fail_safe_monitor_on,
   input wire logic [5:0] pll_prescale,
   input wire logic [3:0] pll_postscale,
   input wire logic reduction_active,
   input wire logic cpu_tick
);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_hold;
      $stable(active_source) [*8];
   endsequence
   // fuse passes a 2-flop sync, the state register and the busy register
   sequence s_fuse_off;
      switch_enable_fuse [*5];
   endsequence
   property p_ready;
      s_setup |=> pready;
   endproperty
   property p_access;
      pready |-> psel && penable;
   endproperty
   property p_err;
      pslverr |-> pready;
   endproperty
   property p_monitor;
      $stable(switch_enable_fuse) [*5]
         |-> fail_safe_monitor_on == !switch_enable_fuse;
   endproperty
   property p_no_switch;
      s_fuse_off |-> !switch_busy;
   endproperty
   property p_cur_fuse;
      (switch_enable_fuse && $stable(initial_source_fuse)) [*6]
         |-> active_source == initial_source_fuse;
   endproperty
   property p_settle;
      $rose(switch_busy) |=> s_hold;
   endproperty
   property p_done;
      $fell(switch_busy) |-> active_source == target_source;
   endproperty
   // tick and enable lag alike
   property p_tick;
      (clk_en && !reduction_active) [*5] |-> $past(cpu_tick);
   endproperty
   property p_post;
      $past(presetn) |-> pll_postscale inside {4'h2, 4'h4, 4'h8};
   endproperty
   property p_pre;
      $past(presetn) |-> pll_prescale inside {[6'h02:6'h21]};
   endproperty
   a_ready: assert property (p_ready)
      else $error("no ready after setup");
   a_access: assert property (p_access)
      else $error("ready outside access");
   a_err: assert property (p_err)
      else $error("error without ready");
   a_monitor: assert property (p_monitor)
      else $error("monitor enable wrong");
   a_no_switch: assert property (p_no_switch)
      else $error("switch while disabled");
   a_cur_fuse: assert property (p_cur_fuse)
      else $error("current source not fuse");
   a_settle: assert property (p_settle)
      else $error("source changed too early");
   a_done: assert property (p_done)
      else $error("switch end without copy");
   a_tick: assert property (p_tick)
      else $error("tick missing at 1:1");
   a_post: assert property (p_post)
      else $error("postscale out of set");
   a_pre: assert property (p_pre)
      else $error("prescale out of range");
endmodule

bind clock_control clock_control_assertions u_chk (.pclk(pclk),
   .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr),
   .switch_enable_fuse(switch_enable_fuse),
   .initial_source_fuse(initial_source_fuse),
   .active_source(active_source), .target_source(target_source),
   .switch_busy(switch_busy), .fail_safe_monitor_on(fail_safe_monitor_on),
   .pll_prescale(pll_prescale), .pll_postscale(pll_postscale),
   .reduction_active(reduction_active), .cpu_tick(cpu_tick));

/* testbench/clock_control_bench.sv */
// self-checking bench for clock_control
module clock_control_bench
   import clock_control_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic switch_enable_fuse, err;
   logic [2:0] initial_source_fuse, active_source, target_source;
   logic [1:0] primary_submode_fuse, primary_submode;
   logic clock_fail_detect, pll_locked, new_source_ready, new_clock;
   logic interrupt_event, secondary_osc_on, switch_busy;
   logic fail_safe_monitor_on, reduction_active, cpu_tick;
   logic [8:0] rc_divide;
   logic [5:0] pll_prescale;
   logic [9:0] pll_multiply;
   logic [3:0] pll_postscale;
   logic signed [5:0] rc_trim;
   int n_mismatch, compares, cyc, cnt;

   clock_control u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .switch_enable_fuse(switch_enable_fuse),
      .initial_source_fuse(initial_source_fuse),
      .primary_submode_fuse(primary_submode_fuse),
      .clock_fail_detect(clock_fail_detect), .pll_locked(pll_locked),
      .new_source_ready(new_source_ready), .new_clock(new_clock),
      .interrupt_event(interrupt_event), .active_source(active_source),
      .target_source(target_source), .primary_submode(primary_submode),
      .secondary_osc_on(secondary_osc_on), .switch_busy(switch_busy),
      .fail_safe_monitor_on(fail_safe_monitor_on),
      .rc_divide(rc_divide), .pll_prescale(pll_prescale),
      .pll_multiply(pll_multiply), .pll_postscale(pll_postscale),
      .rc_trim(rc_trim), .reduction_active(reduction_active),
      .cpu_tick(cpu_tick));

   always #2 pclk = ~pclk;

   task automatic complete_run();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one transfer, then an idle edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      @(posedge pclk);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic osc_wr(input logic [31:0] d);
      wr(UNLOCK_ADDR, {24'h0, UNLOCK_KEY_FIRST});
      wr(UNLOCK_ADDR, {24'h0, UNLOCK_KEY_SECOND});
      wr(OSC_CTRL_ADDR, d);
   endtask

   task automatic ticks();
      cnt = 0;
      repeat (256) begin
         @(posedge pclk);
         if (cpu_tick === 1'b1)
            cnt++;
      end
   endtask

   task automatic nclk(input int n);
      repeat (n) begin
         new_clock <= 1'b1;
         repeat (4) @(posedge pclk);
         new_clock <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask

   task automatic irq();
      interrupt_event <= 1'b1;
      @(posedge pclk);
      interrupt_event <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   initial begin
      {pclk, presetn, psel, penable, pwrite, clock_fail_detect} = '0;
      {pll_locked, new_source_ready, new_clock, interrupt_event} = '0;
      {paddr, pwdata, switch_enable_fuse, initial_source_fuse} = '0;
      clk_en = 1'b1;
      primary_submode_fuse = 2'h1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rdchk(CLK_DIV_ADDR, 32'h3040);
      rdchk(PLL_FB_ADDR, 32'h30);
      rdchk(OSC_CTRL_ADDR, 32'h0);
      chk(pll_multiply, 32'd50);
      chk(pll_postscale, 32'd4);
      chk(rc_divide, 32'd1);
      chk(primary_submode, 32'd1);
      wr(PLL_FB_ADDR, '1);
      rdchk(PLL_FB_ADDR, 32'h1FF);
      wr(RC_TRIM_ADDR, '1);
      rdchk(RC_TRIM_ADDR, 32'h3F);
      wr(CLK_DIV_ADDR, '1);
      rdchk(CLK_DIV_ADDR, 32'hFFDF);
      chk(pll_multiply, 32'd513);
      chk(rc_trim, 32'hFFFFFFFF);
      chk(pll_prescale, 32'd33);
      chk(pll_postscale, 32'd8);
      wr(RC_TRIM_ADDR, 32'h20);
      chk(rc_trim, 32'hFFFFFFE0);
      wr(CLK_DIV_ADDR, 32'h0080);
      rdchk(CLK_DIV_ADDR, 32'h00C0);
      for (int c = 0; c < 8; c++) begin
         wr(CLK_DIV_ADDR, (32'(c) << 12) | (32'(c) << 8) | 32'h0840);
         repeat (3) @(posedge pclk);
         chk(rc_divide, (c == 7) ? 32'd256 : 32'd1 << c);
         ticks();
         chk(cnt, 32'd256 >> c);
      end
      irq();
      chk(reduction_active, 1'b1);
      wr(CLK_DIV_ADDR, 32'hB840);
      irq();
      rdchk(CLK_DIV_ADDR, 32'hB040);
      ticks();
      chk(cnt, 32'd256);
      wr(OSC_CTRL_ADDR, 32'h2);
      chk(secondary_osc_on, 1'b0);
      osc_wr(32'h2);
      chk(secondary_osc_on, 1'b1);
      wr(OSC_CTRL_ADDR, 32'h0);
      rdchk(OSC_CTRL_ADDR, 32'h2);
      rdchk(12'h020, 32'h0);
      chk(err, 1'b1);
      clock_fail_detect <= 1'b1;
      repeat (4) @(posedge pclk);
      clock_fail_detect <= 1'b0;
      rdchk(OSC_CTRL_ADDR, 32'hA);
      osc_wr(32'h2);
      rdchk(OSC_CTRL_ADDR, 32'h2);
      osc_wr(32'h3);
      repeat (4) @(posedge pclk);
      rdchk(OSC_CTRL_ADDR, 32'h2);
      // flag kept by the write; only the start clears it
      clock_fail_detect <= 1'b1;
      {pll_locked, new_source_ready} <= 2'b11;
      repeat (4) @(posedge pclk);
      clock_fail_detect <= 1'b0;
      osc_wr(32'h20B);
      repeat (4) @(posedge pclk);
      chk(switch_busy, 1'b1);
      chk(target_source, 32'd2);
      nclk(9);
      chk(active_source, 32'd0);
      rdchk(OSC_CTRL_ADDR, 32'h0223);
      nclk(1);
      repeat (4) @(posedge pclk);
      chk(active_source, 32'd2);
      chk(switch_busy, 1'b0);
      rdchk(OSC_CTRL_ADDR, 32'h2222);
      switch_enable_fuse <= 1'b1;
      initial_source_fuse <= 3'h5;
      repeat (8) @(posedge pclk);
      chk(active_source, 32'd5);
      chk(fail_safe_monitor_on, 1'b0);
      osc_wr(32'h103);
      clock_fail_detect <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(switch_busy, 1'b0);
      apb(1'b0, OSC_CTRL_ADDR, 32'h0);
      chk(rd & 32'h7009, 32'h5000);
      {clock_fail_detect, presetn} <= 2'b00;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rdchk(CLK_DIV_ADDR, 32'h3040);
      complete_run();
   end
endmodule
